// ### core/ccfi_pkg.sv
// register map, field layout, reset values and fault codes for the
// control-channel fault injection and address remap block.
// assumes a 32-bit apb slave with word-aligned registers.
package ccfi_pkg;

    localparam int ADDR_W = 12;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAULT = 8'h6f;
    localparam logic [7:0] IDX_TGT1 = 8'h70;
    localparam logic [7:0] IDX_TGT2 = 8'h71;
    localparam logic [7:0] IDX_TGT3 = 8'h72;
    localparam logic [7:0] IDX_ALIAS = 8'h80;
    localparam logic [7:0] IDX_STATUS = 8'h81;

    // fault register fields
    localparam int FORCE_BIT = 6;
    localparam int TYPE_LSB = 3;
    localparam int SEL_LSB = 0;

    // target registers hold the 7-bit address in bits 7-1
    localparam int TGT_LSB = 1;

    // alias register fields, 7 bits each
    localparam int ALIAS1_LSB = 0;
    localparam int ALIAS2_LSB = 8;
    localparam int ALIAS3_LSB = 16;

    // status register fields
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_IDX_LSB = 4;
    localparam int STAT_SEQ_LSB = 8;

    // reset values
    localparam logic [2:0] FIELD3_RST = 3'h0;
    localparam logic [6:0] ADDR7_RST = 7'h00;

    // fault codes
    localparam logic [2:0] FT_NONE = 3'h0;
    localparam logic [2:0] FT_CRC = 3'h1;
    localparam logic [2:0] FT_SEQ = 3'h2;
    localparam logic [2:0] FT_DROP = 3'h3;
    localparam logic [2:0] FT_DATA_RND = 3'h4;
    localparam logic [2:0] FT_DATA_B0 = 3'h5;

    // bytes of a block that may carry a fault
    localparam int FRAME_WINDOW = 8;

    // random bit picker
    localparam logic [7:0] LFSR_SEED = 8'ha5;
    localparam logic [7:0] LFSR_TAPS = 8'hb8;

endpackage : ccfi_pkg

// ### core/fault_byte_mutator.sv
// applies one selected fault to a forward control-channel byte.
// assumes apply is high only for the frame that takes the fault, and
// step pulses once per accepted frame to move the random source.
`timescale 1ns/100ps
module fault_byte_mutator (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // frame in
    input wire logic [7:0] data_in,
    input wire logic [2:0] fault_type,
    input wire logic apply,
    input wire logic step,
    // frame out
    output logic [7:0] data_out,
    output logic crc_bad,
    output logic drop,
    output logic skip
);

    logic [7:0] lfsr_r;
    logic [7:0] lfsr_nxt;
    logic [2:0] rnd_bit;
    logic [7:0] flip_rnd;
    logic [7:0] flip_b0;
    logic [7:0] flip_mask;
    logic lfsr_fb;

    // galois style feedback, free of a zero lock-up from the seed
    assign lfsr_fb = lfsr_r[0];
    assign lfsr_nxt = (lfsr_r >> 1) ^ (lfsr_fb ? ccfi_pkg::LFSR_TAPS : 8'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r <= ccfi_pkg::LFSR_SEED;
        end else if (step) begin
            lfsr_r <= lfsr_nxt;
        end
    end

    // bit 0 is excluded; value 0 folds onto bit 7, a small skew accepted
    assign rnd_bit = (lfsr_r[2:0] == 3'h0) ? 3'h7 : lfsr_r[2:0];
    assign flip_rnd = 8'h01 << rnd_bit;
    assign flip_b0 = 8'h01;

    assign flip_mask = !apply ? 8'h00 :
        (fault_type == ccfi_pkg::FT_DATA_RND) ? flip_rnd :
        (fault_type == ccfi_pkg::FT_DATA_B0) ? flip_b0 : 8'h00;

    assign data_out = data_in ^ flip_mask;
    assign crc_bad = apply && (fault_type == ccfi_pkg::FT_CRC);
    assign skip = apply && (fault_type == ccfi_pkg::FT_SEQ);
    assign drop = apply && (fault_type == ccfi_pkg::FT_DROP);

endmodule : fault_byte_mutator

// ### core/ctrl_channel_fault_inject_remap.sv
// forward control-channel frame stage: remaps alias addresses on start
// bytes and injects one software-requested fault into a chosen byte.
// assumes local i2c logic feeds bytes on pclk with a valid/ready pair,
// marks the start (address) byte of each block, and the link side drains
// frames with its own ready. registers sit behind a 32-bit apb slave.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

module ctrl_channel_fault_inject_remap #(
    parameter int SEQ_W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccfi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // local bytes toward the link
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    // forward control-channel frames
    output logic fc_valid,
    input wire logic fc_ready,
    output logic [7:0] fc_data,
    output logic [SEQ_W-1:0] fc_seq,
    output logic fc_crc_bad
);

    // byte address of a register index
    function automatic logic [ccfi_pkg::ADDR_W-1:0] reg_addr(
        input logic [7:0] idx
    );
        reg_addr = {{(ccfi_pkg::ADDR_W-10){1'b0}}, idx, 2'b00};
    endfunction : reg_addr

    // ---- register state
    logic [2:0] fault_type_select_r;
    logic [2:0] fault_byte_select_r;
    logic armed_r;
    logic armed_nxt;
    logic [6:0] remote_target_addr_1_r;
    logic [6:0] remote_target_addr_2_r;
    logic [6:0] remote_target_addr_3_r;
    logic [6:0] alias_addr_1_r;
    logic [6:0] alias_addr_2_r;
    logic [6:0] alias_addr_3_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // ---- apb decode
    logic setup_ph;
    logic wr_en;
    logic hit_fault;
    logic hit_tgt1;
    logic hit_tgt2;
    logic hit_tgt3;
    logic hit_alias;
    logic hit_status;
    logic hit_any;
    logic [31:0] rd_mux;
    logic [31:0] fault_rd;
    logic [31:0] status_rd;

    assign setup_ph = psel && !penable;
    // zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;

    assign hit_fault = paddr == reg_addr(ccfi_pkg::IDX_FAULT);
    assign hit_tgt1 = paddr == reg_addr(ccfi_pkg::IDX_TGT1);
    assign hit_tgt2 = paddr == reg_addr(ccfi_pkg::IDX_TGT2);
    assign hit_tgt3 = paddr == reg_addr(ccfi_pkg::IDX_TGT3);
    assign hit_alias = paddr == reg_addr(ccfi_pkg::IDX_ALIAS);
    assign hit_status = paddr == reg_addr(ccfi_pkg::IDX_STATUS);
    assign hit_any = hit_fault || hit_tgt1 || hit_tgt2 || hit_tgt3 ||
        hit_alias || hit_status;

    // request bit never reads back; bit 7 reserved as zero
    assign fault_rd = (32'h0000_0000
        | (32'(fault_type_select_r) << ccfi_pkg::TYPE_LSB)
        | (32'(fault_byte_select_r) << ccfi_pkg::SEL_LSB));

    // ---- frame path state
    logic [SEQ_W-1:0] seq_r;
    logic [3:0] byte_idx_r;
    logic out_valid_r;
    logic [7:0] out_data_r;
    logic [SEQ_W-1:0] out_seq_r;
    logic out_crc_r;

    assign status_rd = (32'h0000_0000
        | (32'(armed_r) << ccfi_pkg::STAT_ARMED_BIT)
        | (32'(byte_idx_r) << ccfi_pkg::STAT_IDX_LSB)
        | (32'(seq_r) << ccfi_pkg::STAT_SEQ_LSB));

    assign rd_mux =
        hit_fault ? fault_rd :
        hit_tgt1 ? 32'({remote_target_addr_1_r, 1'b0}) :
        hit_tgt2 ? 32'({remote_target_addr_2_r, 1'b0}) :
        hit_tgt3 ? 32'({remote_target_addr_3_r, 1'b0}) :
        hit_alias ? (32'(alias_addr_1_r) << ccfi_pkg::ALIAS1_LSB
            | 32'(alias_addr_2_r) << ccfi_pkg::ALIAS2_LSB
            | 32'(alias_addr_3_r) << ccfi_pkg::ALIAS3_LSB) :
        hit_status ? status_rd : 32'h0000_0000;

    // read data and error are caught in setup so both come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_r <= !hit_any;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = psel && penable && pslverr_r;

    // ---- writable fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_type_select_r <= ccfi_pkg::FIELD3_RST;
            fault_byte_select_r <= ccfi_pkg::FIELD3_RST;
        end else if (wr_en && hit_fault) begin
            fault_type_select_r <= pwdata[ccfi_pkg::TYPE_LSB +: 3];
            fault_byte_select_r <= pwdata[ccfi_pkg::SEL_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_target_addr_1_r <= ccfi_pkg::ADDR7_RST;
            remote_target_addr_2_r <= ccfi_pkg::ADDR7_RST;
            remote_target_addr_3_r <= ccfi_pkg::ADDR7_RST;
        end else if (wr_en) begin
            if (hit_tgt1) begin
                remote_target_addr_1_r <= pwdata[ccfi_pkg::TGT_LSB +: 7];
            end
            if (hit_tgt2) begin
                remote_target_addr_2_r <= pwdata[ccfi_pkg::TGT_LSB +: 7];
            end
            if (hit_tgt3) begin
                remote_target_addr_3_r <= pwdata[ccfi_pkg::TGT_LSB +: 7];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alias_addr_1_r <= ccfi_pkg::ADDR7_RST;
            alias_addr_2_r <= ccfi_pkg::ADDR7_RST;
            alias_addr_3_r <= ccfi_pkg::ADDR7_RST;
        end else if (wr_en && hit_alias) begin
            alias_addr_1_r <= pwdata[ccfi_pkg::ALIAS1_LSB +: 7];
            alias_addr_2_r <= pwdata[ccfi_pkg::ALIAS2_LSB +: 7];
            alias_addr_3_r <= pwdata[ccfi_pkg::ALIAS3_LSB +: 7];
        end
    end

    // ---- frame acceptance
    logic take;
    logic in_window;
    logic [3:0] cur_idx;
    logic hit_byte;
    logic apply;
    logic req_write;

    assign tx_ready = !out_valid_r || fc_ready;
    assign take = tx_valid && tx_ready;

    // a start byte opens a new block at index zero
    assign cur_idx = tx_start ? 4'h0 : byte_idx_r;
    assign in_window = cur_idx < 4'(ccfi_pkg::FRAME_WINDOW);
    assign hit_byte = in_window && (cur_idx[2:0] == fault_byte_select_r);
    assign apply = armed_r && hit_byte;

    // request arms; a request landing on the consuming frame survives
    assign req_write = wr_en && hit_fault && pwdata[ccfi_pkg::FORCE_BIT];
    assign armed_nxt = req_write ? 1'b1 :
        (take && apply) ? 1'b0 : armed_r;

    // ---- address remap on start bytes
    logic [6:0] addr_in;
    logic [6:0] addr_out;
    logic [7:0] remapped;

    assign addr_in = tx_data[7:1];
    assign addr_out =
        (addr_in == alias_addr_1_r) ? remote_target_addr_1_r :
        (addr_in == alias_addr_2_r) ? remote_target_addr_2_r :
        (addr_in == alias_addr_3_r) ? remote_target_addr_3_r : addr_in;
    assign remapped = tx_start ? {addr_out, tx_data[0]} : tx_data;

    // ---- fault application
    logic [7:0] mut_data;
    logic mut_crc;
    logic mut_drop;
    logic mut_skip;

    fault_byte_mutator u_mutator (
        .pclk(pclk),
        .presetn(presetn),
        .data_in(remapped),
        .fault_type(fault_type_select_r),
        .apply(apply),
        .step(take),
        .data_out(mut_data),
        .crc_bad(mut_crc),
        .drop(mut_drop),
        .skip(mut_skip)
    );

    // ---- sequence numbering
    logic [SEQ_W-1:0] seq_use;
    logic [SEQ_W-1:0] seq_nxt;

    // skipped number is simply never sent; a dropped frame still uses one
    assign seq_use = mut_skip ? seq_r + SEQ_W'(1) : seq_r;
    assign seq_nxt = seq_use + SEQ_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
            seq_r <= '0;
            byte_idx_r <= 4'h0;
        end else begin
            armed_r <= armed_nxt;
            if (take) begin
                seq_r <= seq_nxt;
                // saturate past the window so late bytes never match
                byte_idx_r <= in_window ? cur_idx + 4'h1 : cur_idx;
            end
        end
    end

    // ---- output register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_r <= 1'b0;
            out_data_r <= 8'h00;
            out_seq_r <= '0;
            out_crc_r <= 1'b0;
        end else if (take) begin
            out_valid_r <= !mut_drop;
            out_data_r <= mut_data;
            out_seq_r <= seq_use;
            out_crc_r <= mut_crc;
        end else if (fc_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    assign fc_valid = out_valid_r;
    assign fc_data = out_data_r;
    assign fc_seq = out_seq_r;
    assign fc_crc_bad = out_crc_r;

endmodule : ctrl_channel_fault_inject_remap

// ### bench/ccfi_asserts.sv
// port checker for the fault-injection and remap frame stage.
// assumes the armed fault is mirrored from apb writes seen at the ports.
`timescale 1ns/100ps
module ccfi_asserts #(
    parameter int SEQ_W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccfi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // frames
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    input wire logic fc_valid,
    input wire logic fc_ready,
    input wire logic [7:0] fc_data,
    input wire logic [SEQ_W-1:0] fc_seq,
    input wire logic fc_crc_bad
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic armed_r;
    logic [2:0] typ_r;
    logic [2:0] sel_r;
    logic [3:0] idx_r;
    wire fault_sel = paddr == {2'b00, ccfi_pkg::IDX_FAULT, 2'b00};
    wire take = tx_valid && tx_ready;
    wire wr_fault = psel && penable && pwrite && fault_sel;
    wire [3:0] cur_idx = tx_start ? 4'h0 : idx_r;
    wire hit = take && armed_r && cur_idx == {1'b0, sel_r};
    // set wins over an injection on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
            typ_r <= 3'h0;
            sel_r <= 3'h0;
            idx_r <= 4'h0;
        end else begin
            if (take) idx_r <= (cur_idx == 4'h8) ? 4'h8 : cur_idx + 4'h1;
            if (wr_fault) typ_r <= pwdata[5:3];
            if (wr_fault) sel_r <= pwdata[2:0];
            armed_r <= (wr_fault && pwdata[6]) || (armed_r && !hit);
        end
    end
    sequence hit_s(logic [2:0] t);
        hit && typ_r == t;
    endsequence
    chk_ready_follows_link: assert property (
        tx_ready == (!fc_valid || fc_ready)) else $error("tx_ready wrong");
    chk_frame_holds: assert property (
        fc_valid && !fc_ready |=> fc_valid && $stable(fc_data)
        && $stable(fc_seq) && $stable(fc_crc_bad)) else $error("frame moved");
    chk_force_reads_zero: assert property (
        psel && penable && !pwrite && fault_sel |-> !prdata[6])
        else $error("request bit read back");
    chk_clean_pass: assert property (
        take && !hit && !tx_start |=> fc_valid && !fc_crc_bad
        && fc_data == $past(tx_data)) else $error("byte altered");
    chk_crc_inject: assert property (
        hit_s(ccfi_pkg::FT_CRC) |=> fc_valid && fc_crc_bad)
        else $error("crc fault missing");
    chk_drop_frame: assert property (
        hit_s(ccfi_pkg::FT_DROP) |=> !fc_valid) else $error("frame not dropped");
    chk_bit0_flip: assert property (
        hit_s(ccfi_pkg::FT_DATA_B0) ##0 !tx_start
        |=> fc_data == ($past(tx_data) ^ 8'h01)) else $error("bit 0 not flipped");
    chk_rand_bit: assert property (
        hit_s(ccfi_pkg::FT_DATA_RND) ##0 !tx_start |=> fc_valid
        && $onehot(fc_data ^ $past(tx_data)) && fc_data[0] == $past(tx_data[0]))
        else $error("random flip wrong");
endmodule : ccfi_asserts

// ### bench/link_sink.sv
// far-end frame receiver: stalls at random and counts sequence gaps.
// assumes frames are taken on edges with fc_valid and fc_ready high.
`timescale 1ns/100ps
module link_sink #(
    parameter int SEQ_W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // frames
    input wire logic fc_valid,
    input wire logic [SEQ_W-1:0] fc_seq,
    output logic fc_ready,
    output logic [7:0] gaps
);
    logic [15:0] st;
    logic [SEQ_W-1:0] exp_seq;
    logic seen;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= 16'h1d2b;
            fc_ready <= 1'b0;
            gaps <= 8'h00;
            exp_seq <= '0;
            seen <= 1'b0;
        end else begin
            st <= {st[14:0], st[15] ^ st[13] ^ st[12] ^ st[10]};
            // stalls about a quarter of cycles to exercise backpressure
            fc_ready <= st[0] | st[1];
            if (fc_valid && fc_ready) begin
                if (seen && fc_seq != exp_seq) gaps <= gaps + 8'h01;
                seen <= 1'b1;
                exp_seq <= fc_seq + 1'b1;
            end
        end
    end
endmodule : link_sink

// ### bench/ctrl_channel_fault_inject_remap_tb.sv
// bench for the fault-injection and remap stage with a random far end.
// assumes a 100 ns pclk and the apb map of the package indices.
`timescale 1ns/100ps
module ctrl_channel_fault_inject_remap_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic tx_valid = 0, tx_start = 0, pready, pslverr, tx_ready;
    logic fc_valid, fc_ready, fc_crc_bad, er, armed = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] tx_data = 0, fc_data, gaps, g0;
    logic [3:0] fc_seq, idx = 0;
    logic [15:0] lf = 16'h0cc5;
    logic [10:0] expq[$];
    logic [2:0] typ, sel;
    logic [6:0] al1 = 7'h21, al2 = 7'h32, tg1, tg2;
    int num_errors = 0, total_checks = 0;
    always #50 pclk = ~pclk;
    ctrl_channel_fault_inject_remap #(.SEQ_W(4)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .tx_start(tx_start), .fc_valid(fc_valid),
        .fc_ready(fc_ready), .fc_data(fc_data), .fc_seq(fc_seq),
        .fc_crc_bad(fc_crc_bad));
    link_sink #(.SEQ_W(4)) far (.pclk(pclk), .presetn(presetn),
        .fc_valid(fc_valid), .fc_seq(fc_seq), .fc_ready(fc_ready), .gaps(gaps));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function automatic logic [11:0] adr(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction : adr
    function automatic logic [7:0] remap(input logic [7:0] d);
        return d[7:1] == al1 ? {tg1, d[0]} : d[7:1] == al2 ? {tg2, d[0]} : d;
    endfunction : remap
    task summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // answer is taken only at the rising edge that sees pready high
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        if (n == 20) begin num_errors++; summarize(); end
    endtask : apb
    task send(input logic [7:0] d, input logic s);
        int n;
        logic [10:0] q;
        logic [3:0] ci;
        tx_valid <= 1; tx_data <= d; tx_start <= s;
        ci = s ? 4'h0 : idx;
        q = {3'b000, s ? remap(d) : d};
        if (armed && ci == {1'b0, sel}) begin
            armed = 0;
            if (typ == 3'h1) q[8] = 1;
            if (typ == 3'h3) q[10] = 1;
            if (typ == 3'h4) q[9] = 1;
            if (typ == 3'h5) q[0] = ~q[0];
        end
        idx = (ci == 4'h8) ? 4'h8 : ci + 4'h1;
        if (!q[10]) expq.push_back(q);
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (tx_ready === 1'b1) break;
        end
        if (n == 50) begin num_errors++; summarize(); end
    endtask : send
    task block(input logic [6:0] a);
        int i;
        send({a, lf[0]}, 1);
        for (i = 0; i < 9; i++) begin lf = lfsr(lf); send(lf[7:0], 0); end
        tx_valid <= 0;
        for (i = 0; i < 200 && expq.size() > 0; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(expq.size() == 0, "frames missing");
    endtask : block
    always @(posedge pclk) begin : mon
        logic [10:0] q;
        if (presetn && fc_valid && fc_ready) begin
            q = expq.size() > 0 ? expq.pop_front() : 11'h7ff;
            chk(fc_crc_bad === q[8], "crc flag");
            if (q[9]) chk(fc_data[0] === q[0] && $onehot(fc_data ^ q[7:0]),
                "random flip");
            else chk(fc_data === q[7:0], "frame data");
        end
    end
    initial begin
        int t;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, adr(ccfi_pkg::IDX_FAULT), 0);
        chk(rd === 32'h0000_0000, "fault reset");
        apb(0, adr(ccfi_pkg::IDX_TGT3), 0);
        chk(rd === 32'h0000_0000, "target reset");
        apb(0, 12'h3fc, 0);
        chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped access");
        lf = lfsr(lf);
        tg1 = lf[6:0];
        tg2 = lf[14:8];
        apb(1, adr(ccfi_pkg::IDX_TGT1), {24'h00_0000, tg1, 1'b1});
        apb(0, adr(ccfi_pkg::IDX_TGT1), 0);
        chk(rd === {24'h00_0000, tg1, 1'b0}, "target read");
        apb(1, adr(ccfi_pkg::IDX_TGT2), {24'h00_0000, tg2, 1'b0});
        apb(1, adr(ccfi_pkg::IDX_ALIAS), {17'h0_0000, al2, 1'b0, al1});
        for (t = 0; t < 8; t++) begin
            lf = lfsr(lf);
            typ = t;
            sel = t == 0 ? 3'h0 : t == 7 ? 3'h7 : lf[2:0];
            apb(1, adr(ccfi_pkg::IDX_FAULT), {25'h000_0000, 1'b1, typ, sel});
            armed = 1;
            apb(0, adr(ccfi_pkg::IDX_FAULT), 0);
            chk(rd === {26'h000_0000, typ, sel}, "fault read");
            g0 = gaps;
            block(t[0] ? al1 : al2);
            chk(gaps - g0 === 8'((typ == 2) || (typ == 3)), "gap");
            block(al1);
            chk(gaps - g0 === 8'((typ == 2) || (typ == 3)), "late gap");
        end
        summarize();
    end
endmodule : ctrl_channel_fault_inject_remap_tb
bind ctrl_channel_fault_inject_remap ccfi_asserts #(.SEQ_W(SEQ_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_start(tx_start), .fc_valid(fc_valid), .fc_ready(fc_ready),
    .fc_data(fc_data), .fc_seq(fc_seq), .fc_crc_bad(fc_crc_bad));
